/* File: hdl/wsf_pkg.sv */
package wsf_pkg;

	// address and line geometry
	localparam int ADDR_W      = 32;             // physical address width
	localparam int LINE_BYTES  = 64;             // coherency unit in bytes
	localparam int LINE_OFS_W  = 6;              // byte offset bits inside a line
	localparam int LINE_W      = LINE_BYTES * 8; // line width in bits
	localparam int DATA_BYTES  = 16;             // widest store operand in bytes
	localparam int DATA_W      = DATA_BYTES * 8; // store operand width in bits
	localparam int PS_ALIGN_W  = 4;              // packed single store needs 16-byte alignment
	localparam int MSB_OF_BYTE = 7;              // mask bit that enables a byte lane
	localparam int PEND_W      = 4;              // width of the pending access counts

	// zero constants sized to what they meet
	localparam logic [PS_ALIGN_W-1:0] ALIGN_ZERO = 4'h0;
	localparam logic [PEND_W-1:0]     PEND_ZERO  = 4'h0;
	localparam logic [LINE_OFS_W-1:0] OFS_ZERO   = 6'h00;

	// operations from the core
	typedef enum logic [3:0] {
		OP_NT_INT  = 4'h0, // packed integer non-temporal store
		OP_NT_PS   = 4'h1, // packed single non-temporal store, aligned
		OP_NT_MASK = 4'h2, // byte-masked non-temporal store
		OP_SFENCE  = 4'h3, // store barrier
		OP_LFENCE  = 4'h4, // load barrier
		OP_MFENCE  = 4'h5, // full barrier
		OP_FLUSH   = 4'h6  // cache line flush
	} wsf_op_t;

	// memory types as given by page_attribute_table or range_type_registers
	typedef enum logic [2:0] {
		MT_UNCACHED = 3'h0,
		MT_COMBINE  = 3'h1, // write_combining_type
		MT_THROUGH  = 3'h4, // write_through_type
		MT_PROTECT  = 3'h5,
		MT_BACK     = 3'h6  // write_back_type
	} wsf_mtype_t;

	// commands toward the cache hierarchy
	typedef enum logic [1:0] {
		CC_NONE   = 2'h0,
		CC_UPDATE = 2'h1, // merge store bytes into the cached line
		CC_PEEK   = 2'h2, // return line data and its dirty state, no change
		CC_INVAL  = 2'h3  // invalidate in all levels, data and instruction
	} wsf_ccmd_t;

	// commands toward the system bus
	typedef enum logic [1:0] {
		BC_NONE  = 2'h0,
		BC_WRITE = 2'h1, // full or partial line write with byte enables
		BC_INVAL = 2'h2  // invalidate broadcast to the coherence domain
	} wsf_bcmd_t;

	// control states, one-hot
	typedef enum logic [8:0] {
		S_IDLE   = 9'h001,
		S_MERGE  = 9'h002,
		S_DRAIN  = 9'h004,
		S_PEEK   = 9'h008,
		S_WRBACK = 9'h010,
		S_INVAL  = 9'h020,
		S_BCAST  = 9'h040,
		S_UPDATE = 9'h080,
		S_FWAIT  = 9'h100
	} wsf_state_t;

	// request from the execution core
	typedef struct packed {
		wsf_op_t             op;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   data;
		logic [DATA_BYTES-1:0][7:0] mask;
		wsf_mtype_t          mtype;
	} wsf_req_t;

	// request toward the cache hierarchy
	typedef struct packed {
		wsf_ccmd_t           cmd;
		logic [ADDR_W-1:0]   addr;
		logic [LINE_W-1:0]   data;
		logic [LINE_BYTES-1:0] be;
	} wsf_creq_t;

	// request toward the system bus
	typedef struct packed {
		wsf_bcmd_t           cmd;
		logic [ADDR_W-1:0]   addr;
		logic [LINE_W-1:0]   data;
		logic [LINE_BYTES-1:0] be;
		wsf_mtype_t          mtype;
	} wsf_breq_t;

endpackage

/* File: hdl/wsf_wc_buf.sv */
`timescale 1ns/1ns

// one write-combining line: merges bytes, last write to a byte wins
module wsf_wc_buf (
	input  wire logic                              ref_clk,
	input  wire logic                              rst_n,
	input  wire logic                              ce,
	input  wire logic                              wr_en,
	input  wire logic [wsf_pkg::ADDR_W-1:0]        wr_line,
	input  wire logic [wsf_pkg::LINE_W-1:0]        wr_data,
	input  wire logic [wsf_pkg::LINE_BYTES-1:0]    wr_be,
	input  wire wsf_pkg::wsf_mtype_t               wr_mtype,
	input  wire logic                              clr,
	output logic                                   valid_q,
	output logic [wsf_pkg::ADDR_W-1:0]             line_q,
	output logic [wsf_pkg::LINE_W-1:0]             data_q,
	output logic [wsf_pkg::LINE_BYTES-1:0]         be_q,
	output wsf_pkg::wsf_mtype_t                    mtype_q
);

	// line tag and bus memory type come from the first store
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			valid_q <= 1'b0;
			line_q  <= '0;
			mtype_q <= wsf_pkg::MT_UNCACHED;
		end else if (ce) begin
			if (wr_en && !valid_q) begin
				line_q  <= wr_line;
				mtype_q <= wr_mtype;
			end
			// a write in the clear cycle keeps the line valid; the tag reloads only if it was empty
			valid_q <= wr_en | (valid_q & ~clr);
		end
	end

	// per lane: last write wins, clear drops lanes
	for (genvar i = 0; i < wsf_pkg::LINE_BYTES; i++) begin : g_lane
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				data_q[i*8 +: 8] <= 8'h00;
				be_q[i]          <= 1'b0;
			end else if (ce) begin
				if (wr_en && wr_be[i]) begin
					data_q[i*8 +: 8] <= wr_data[i*8 +: 8];
					be_q[i]          <= 1'b1;
				end else if (clr || (wr_en && !valid_q)) begin
					be_q[i]          <= 1'b0;
				end
			end
		end
	end

endmodule

/* File: hdl/wsf_unit.sv */
`timescale 1ns/1ns

// Function
// - store barrier orders earlier stores before later
// - load barrier orders earlier loads before later
// - full barrier orders all earlier accesses first
// - load and store barriers mutually unordered
// - integer streaming stores weak, never allocate
// - packed single store misaligned raises protection fault
// - masked store writes bytes with mask msb
// - masked store address from destination index
// - flush invalidates line in every cache
// - flush invalidation broadcast to all agents
// - dirty flushed line written back first
// - flush covers 64 bytes, memory type ignored
// - flush allowed anywhere, byte load checks
// - flushes unordered except against full barrier
// - combined store data may stay buffered
// - bus memory type from first store
// - combining region reads never fill caches
// - in-place hit updates cache, fence ignores
// - eviction mode writes dirty cached copy out first
// - same line writes merge, last wins
module wsf_unit #(
	parameter bit IN_PLACE = 1'b0 // 1: streaming hits update the cache in place
) (
	input  wire logic                          ref_clk,
	input  wire logic                          reset_n,
	input  wire logic                          ce,
	input  wire logic                          req_valid,
	output logic                               req_ready,
	input  wire wsf_pkg::wsf_req_t             req,
	input  wire logic [wsf_pkg::ADDR_W-1:0]    dest_index,
	input  wire logic                          perm_fault,
	input  wire logic                          lookup_hit,
	input  wire logic [wsf_pkg::PEND_W-1:0]    ld_pend,
	input  wire logic [wsf_pkg::PEND_W-1:0]    st_pend,
	output logic                               done_q,
	output logic                               fault_q,
	input  wire wsf_pkg::wsf_mtype_t           rd_mtype,
	output logic                               rd_no_alloc,
	output logic                               cache_valid,
	output wsf_pkg::wsf_creq_t                 cache_req,
	input  wire logic                          cache_ack,
	input  wire logic                          cache_dirty,
	input  wire logic [wsf_pkg::LINE_W-1:0]    cache_data,
	output logic                               bus_valid,
	output wsf_pkg::wsf_breq_t                 bus_req,
	input  wire logic                          bus_ack
);

	// reset release synchroniser, assert is immediate
	logic rst_meta_q;                         // first stage, read only by second
	logic rst_n;                              // synchronised reset for all logic

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// latched operation
	wsf_pkg::wsf_state_t               state_q;   // control state
	wsf_pkg::wsf_state_t               state_d;
	wsf_pkg::wsf_op_t                  op_q;      // operation in progress
	logic [wsf_pkg::ADDR_W-1:0]        addr_q;    // effective address
	logic [wsf_pkg::LINE_W-1:0]        ldata_q;   // store data placed in line
	logic [wsf_pkg::LINE_BYTES-1:0]    lbe_q;     // store byte enables in line
	wsf_pkg::wsf_mtype_t               mtype_q;   // memory type of the store
	logic [wsf_pkg::LINE_W-1:0]        wbdata_q;  // dirty line captured for write back
	logic                              done_d;
	logic                              fault_d;

	// combining buffer outputs
	logic                              wc_valid;
	logic [wsf_pkg::ADDR_W-1:0]        wc_line;
	logic [wsf_pkg::LINE_W-1:0]        wc_data;
	logic [wsf_pkg::LINE_BYTES-1:0]    wc_be;
	wsf_pkg::wsf_mtype_t               wc_mtype;

	// request decode, all continuous
	wire                               accept   = req_valid & req_ready;
	wire                               is_mask  = (req.op == wsf_pkg::OP_NT_MASK);
	wire                               is_store = (req.op == wsf_pkg::OP_NT_INT) |
	                                              (req.op == wsf_pkg::OP_NT_PS) | is_mask;
	// masked store targets the index register
	wire [wsf_pkg::ADDR_W-1:0]         eff_addr = is_mask ? dest_index : req.addr;
	wire [wsf_pkg::LINE_OFS_W-1:0]     ofs      = eff_addr[wsf_pkg::LINE_OFS_W-1:0];
	wire                               misalign = (req.op == wsf_pkg::OP_NT_PS) &&
	                (eff_addr[wsf_pkg::PS_ALIGN_W-1:0] != wsf_pkg::ALIGN_ZERO);
	// only a cacheable hit takes the in-place or eviction path
	wire                               cacheable = (req.mtype == wsf_pkg::MT_BACK) |
	                                               (req.mtype == wsf_pkg::MT_THROUGH);
	wire                               hit_path  = lookup_hit & cacheable;
	// flush acts on the whole line; memory type not consulted
	wire [wsf_pkg::ADDR_W-1:0]         line_addr = {eff_addr[wsf_pkg::ADDR_W-1:
	                                       wsf_pkg::LINE_OFS_W], wsf_pkg::OFS_ZERO};
	wire                               same_line = wc_line == {addr_q[wsf_pkg::ADDR_W-1:
	                                       wsf_pkg::LINE_OFS_W], wsf_pkg::OFS_ZERO};
	wire                               st_quiet  = (st_pend == wsf_pkg::PEND_ZERO);
	wire                               ld_quiet  = (ld_pend == wsf_pkg::PEND_ZERO);

	// byte enables: mask msb for the masked store, else all
	logic [wsf_pkg::DATA_BYTES-1:0]    op_be;
	for (genvar b = 0; b < wsf_pkg::DATA_BYTES; b++) begin : g_be
		assign op_be[b] = is_mask ? req.mask[b][wsf_pkg::MSB_OF_BYTE] : 1'b1;
	end

	// place operand in its lanes; bytes past the line end drop
	wire [wsf_pkg::LINE_W-1:0]         wide_data = {{(wsf_pkg::LINE_W-wsf_pkg::DATA_W){1'b0}},
	                                                req.data};
	wire [wsf_pkg::LINE_BYTES-1:0]     wide_be   = {{(wsf_pkg::LINE_BYTES-
	                                                wsf_pkg::DATA_BYTES){1'b0}}, op_be};
	wire [wsf_pkg::LINE_W-1:0]         pl_data   = wide_data << {ofs, 3'h0};
	wire [wsf_pkg::LINE_BYTES-1:0]     pl_be     = wide_be << ofs;

	// combining-region reads, speculative too, bypass every cache
	assign rd_no_alloc = (rd_mtype == wsf_pkg::MT_COMBINE);

	// handshakes
	assign req_ready   = ce & rst_n & (state_q == wsf_pkg::S_IDLE);
	assign cache_valid = (state_q == wsf_pkg::S_PEEK) | (state_q == wsf_pkg::S_INVAL) |
	                     (state_q == wsf_pkg::S_UPDATE);
	assign bus_valid   = (state_q == wsf_pkg::S_DRAIN) | (state_q == wsf_pkg::S_WRBACK) |
	                     (state_q == wsf_pkg::S_BCAST);

	// merge writes only a matching or empty buffer
	wire                               wc_wr  = (state_q == wsf_pkg::S_MERGE) &
	                                            (~wc_valid | same_line);
	wire                               wc_clr = (state_q == wsf_pkg::S_DRAIN) & bus_ack;

	// cache request fields, all from flops
	always_comb begin
		cache_req      = '0;
		cache_req.addr = addr_q;
		cache_req.data = ldata_q;
		cache_req.be   = lbe_q;
		unique case (state_q)
			wsf_pkg::S_PEEK:   cache_req.cmd = wsf_pkg::CC_PEEK;
			// invalidation reaches every level, instruction caches included
			wsf_pkg::S_INVAL:  cache_req.cmd = wsf_pkg::CC_INVAL;
			wsf_pkg::S_UPDATE: cache_req.cmd = wsf_pkg::CC_UPDATE;
			default:           cache_req.cmd = wsf_pkg::CC_NONE;
		endcase
	end

	// bus request fields, all from flops
	always_comb begin
		bus_req = '0;
		unique case (state_q)
			wsf_pkg::S_DRAIN: begin
				// one bus write for the whole combined line
				bus_req.cmd   = wsf_pkg::BC_WRITE;
				bus_req.addr  = wc_line;
				bus_req.data  = wc_data;
				bus_req.be    = wc_be;
				bus_req.mtype = wc_mtype;
			end
			wsf_pkg::S_WRBACK: begin
				bus_req.cmd   = wsf_pkg::BC_WRITE;
				bus_req.addr  = addr_q;
				bus_req.data  = wbdata_q;
				bus_req.be    = '1;
				bus_req.mtype = wsf_pkg::MT_BACK;
			end
			wsf_pkg::S_BCAST: begin
				bus_req.cmd   = wsf_pkg::BC_INVAL;
				bus_req.addr  = addr_q;
				bus_req.mtype = mtype_q;
			end
			default: bus_req.cmd = wsf_pkg::BC_NONE;
		endcase
	end

	// next state and completion
	always_comb begin
		state_d = state_q;
		done_d  = 1'b0;
		fault_d = 1'b0;
		unique case (state_q)
			wsf_pkg::S_IDLE: begin
				if (accept) begin
					if (misalign || (req.op == wsf_pkg::OP_FLUSH && perm_fault)) begin
						// protection fault: nothing reaches the caches or the bus
						done_d  = 1'b1;
						fault_d = 1'b1;
					end else if (is_store && hit_path) begin
						state_d = IN_PLACE ? wsf_pkg::S_UPDATE : wsf_pkg::S_PEEK;
					end else if (is_store) begin
						// a miss never reads for ownership nor allocates
						state_d = wsf_pkg::S_MERGE;
					end else if (req.op == wsf_pkg::OP_FLUSH) begin
						// flush does not wait on buffered stores or other flushes
						state_d = wsf_pkg::S_PEEK;
					end else if (req.op == wsf_pkg::OP_LFENCE) begin
						// load barrier leaves combined stores buffered
						state_d = wsf_pkg::S_FWAIT;
					end else begin
						state_d = wc_valid ? wsf_pkg::S_DRAIN : wsf_pkg::S_FWAIT;
					end
				end
			end
			wsf_pkg::S_MERGE: begin
				// data stays buffered until a store or full barrier or a line change
				if (wc_valid && !same_line) begin
					state_d = wsf_pkg::S_DRAIN;
				end else begin
					state_d = wsf_pkg::S_IDLE;
					done_d  = 1'b1;
				end
			end
			wsf_pkg::S_DRAIN: begin
				if (bus_ack) begin
					state_d = (op_q == wsf_pkg::OP_SFENCE || op_q == wsf_pkg::OP_MFENCE) ?
					          wsf_pkg::S_FWAIT : wsf_pkg::S_MERGE;
				end
			end
			wsf_pkg::S_PEEK: begin
				if (cache_ack) begin
					state_d = cache_dirty ? wsf_pkg::S_WRBACK : wsf_pkg::S_INVAL;
				end
			end
			wsf_pkg::S_WRBACK: begin
				if (bus_ack) begin
					state_d = wsf_pkg::S_INVAL;
				end
			end
			wsf_pkg::S_INVAL: begin
				if (cache_ack) begin
					// evicted streaming store continues into the buffer
					state_d = (op_q == wsf_pkg::OP_FLUSH) ? wsf_pkg::S_BCAST :
					          wsf_pkg::S_MERGE;
				end
			end
			wsf_pkg::S_BCAST: begin
				if (bus_ack) begin
					state_d = wsf_pkg::S_IDLE;
					done_d  = 1'b1;
				end
			end
			wsf_pkg::S_UPDATE: begin
				// in-place data now lives in the cache; later barriers skip it
				if (cache_ack) begin
					state_d = wsf_pkg::S_IDLE;
					done_d  = 1'b1;
				end
			end
			wsf_pkg::S_FWAIT: begin
				// retire once the ordered class of accesses is seen
				unique case (op_q)
					wsf_pkg::OP_SFENCE: done_d = st_quiet;
					wsf_pkg::OP_LFENCE: done_d = ld_quiet;
					default:            done_d = st_quiet & ld_quiet;
				endcase
				if (done_d) begin
					state_d = wsf_pkg::S_IDLE;
				end
			end
			default: begin
				state_d = wsf_pkg::S_IDLE;
			end
		endcase
	end

	// state and completion flops
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= wsf_pkg::S_IDLE;
			done_q  <= 1'b0;
			fault_q <= 1'b0;
		end else if (ce) begin
			state_q <= state_d;
			done_q  <= done_d;
			fault_q <= fault_d;
		end
	end

	// operand capture on accept
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			op_q    <= wsf_pkg::OP_NT_INT;
			addr_q  <= '0;
			ldata_q <= '0;
			lbe_q   <= '0;
			mtype_q <= wsf_pkg::MT_UNCACHED;
		end else if (ce && accept) begin
			op_q    <= req.op;
			addr_q  <= (req.op == wsf_pkg::OP_FLUSH) ? line_addr : eff_addr;
			ldata_q <= pl_data;
			lbe_q   <= pl_be;
			mtype_q <= req.mtype;
		end
	end

	// dirty line kept for write back
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wbdata_q <= '0;
		end else if (ce && state_q == wsf_pkg::S_PEEK && cache_ack) begin
			wbdata_q <= cache_data;
		end
	end

	// the single combining line
	wsf_wc_buf u_wc_buf (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.wr_en    (wc_wr),
		.wr_line  ({addr_q[wsf_pkg::ADDR_W-1:wsf_pkg::LINE_OFS_W], wsf_pkg::OFS_ZERO}),
		.wr_data  (ldata_q),
		.wr_be    (lbe_q),
		.wr_mtype (mtype_q),
		.clr      (wc_clr),
		.valid_q  (wc_valid),
		.line_q   (wc_line),
		.data_q   (wc_data),
		.be_q     (wc_be),
		.mtype_q  (wc_mtype)
	);

endmodule

/* File: tb/wsf_props.sv */
`timescale 1ns/1ns

// port-level checks on the weak-ordering unit
module wsf_props #(
	parameter bit IN_PLACE = 1'b0 // 1: in-place update allowed
) (
	input wire logic                       ref_clk,
	input wire logic                       reset_n,
	input wire logic                       req_valid,
	input wire logic                       req_ready,
	input wire wsf_pkg::wsf_req_t          req,
	input wire logic                       perm_fault,
	input wire logic [wsf_pkg::PEND_W-1:0] ld_pend,
	input wire logic [wsf_pkg::PEND_W-1:0] st_pend,
	input wire logic                       done_q,
	input wire logic                       fault_q,
	input wire wsf_pkg::wsf_mtype_t        rd_mtype,
	input wire logic                       rd_no_alloc,
	input wire logic                       cache_valid,
	input wire wsf_pkg::wsf_creq_t         cache_req,
	input wire logic                       cache_ack,
	input wire logic                       cache_dirty,
	input wire logic                       bus_valid,
	input wire wsf_pkg::wsf_breq_t         bus_req
);
	wsf_pkg::wsf_op_t op_q; // last taken op
	wire acc    = req_valid && req_ready; // ready folds in ce
	wire c_peek = cache_valid && cache_req.cmd == wsf_pkg::CC_PEEK;
	wire c_inv  = cache_valid && cache_req.cmd == wsf_pkg::CC_INVAL;
	wire peek   = c_peek && cache_ack;
	wire inval  = c_inv && cache_ack;
	wire b_full = bus_valid && bus_req.cmd == wsf_pkg::BC_WRITE && &bus_req.be;
	wire b_inv  = bus_valid && bus_req.cmd == wsf_pkg::BC_INVAL;
	wire upd    = cache_valid && cache_req.cmd == wsf_pkg::CC_UPDATE;
	wire quiet  = !bus_valid && !cache_valid;
	wire fl     = acc && req.op == wsf_pkg::OP_FLUSH;
	wire bad_ps = acc && req.op == wsf_pkg::OP_NT_PS && req.addr[3:0] != 4'h0;
	wire sf     = op_q == wsf_pkg::OP_SFENCE || op_q == wsf_pkg::OP_MFENCE;
	wire lf     = op_q == wsf_pkg::OP_LFENCE || op_q == wsf_pkg::OP_MFENCE;

	// op that the next retirement belongs to
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			op_q <= wsf_pkg::OP_NT_INT;
		else if (acc)
			op_q <= req.op;
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	a_misalign_fault: assert property (bad_ps |=> done_q && fault_q && quiet)
		else $error("misaligned store not faulted");
	a_fault_pair: assert property (fault_q |-> done_q)
		else $error("fault without retirement");
	a_flush_perm: assert property (fl && perm_fault |=> done_q && fault_q)
		else $error("flush fault missing");
	a_flush_peek: assert property (fl && !perm_fault |=> c_peek)
		else $error("flush skipped lookup");
	a_dirty_wback: assert property (peek && cache_dirty |=> b_full)
		else $error("dirty line not written back");
	a_clean_inval: assert property (peek && !cache_dirty |=> c_inv)
		else $error("clean line not invalidated");
	a_inval_bcast: assert property (inval && op_q == wsf_pkg::OP_FLUSH |=> b_inv)
		else $error("invalidate not broadcast");
	a_store_fence: assert property (done_q && sf |-> $past(st_pend) == 4'h0)
		else $error("store barrier retired early");
	a_load_fence: assert property (done_q && lf |-> $past(ld_pend) == 4'h0)
		else $error("load barrier retired early");
	a_read_nofill: assert property (rd_no_alloc == (rd_mtype == wsf_pkg::MT_COMBINE))
		else $error("combining read may fill caches");
	a_no_update: assert property (IN_PLACE || !upd)
		else $error("store allocated in cache");
endmodule

bind wsf_unit wsf_props #(.IN_PLACE(IN_PLACE)) u_props (.*);

/* File: tb/wsf_mem_model.sv */
`timescale 1ns/1ns

// cache hierarchy and bus seen from the unit; acks after one or four cycles
module wsf_mem_model (
	input  wire logic                  ref_clk,
	input  wire logic                  reset_n,
	input  wire logic                  slow,        // 1: hold acks off three cycles
	input  wire logic                  dirty,       // line state a lookup reports
	input  wire logic                  cache_valid,
	input  wire wsf_pkg::wsf_creq_t    cache_req,
	input  wire logic                  bus_valid,
	input  wire wsf_pkg::wsf_breq_t    bus_req,
	output logic                       cache_ack,
	output logic                       cache_dirty,
	output logic [wsf_pkg::LINE_W-1:0] cache_data,
	output logic                       bus_ack
);
	logic [1:0] cw_q; // cycles a cache command waited
	logic [1:0] bw_q; // cycles a bus request waited
	wire [1:0]  dly  = slow ? 2'h3 : 2'h0; // 2-bit counts wrap: a pace change stays bounded
	wire [31:0] ln   = {cache_req.addr[31:6], 6'h00};
	wire        peek = cache_ack && cache_req.cmd == wsf_pkg::CC_PEEK;

	assign cache_ack = cache_valid && cw_q == dly;
	assign bus_ack = bus_valid && bw_q == dly;
	// line data follows the address; inverse off a peek ack
	assign cache_data = peek ? {16{ln}} : ~{16{ln}};
	assign cache_dirty = peek ? dirty : ~dirty;

	// wait counters restart on every ack
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cw_q <= 2'h0;
			bw_q <= 2'h0;
		end else begin
			cw_q <= (cache_valid && !cache_ack) ? cw_q + 2'h1 : 2'h0;
			bw_q <= (bus_valid && !bus_ack) ? bw_q + 2'h1 : 2'h0;
		end
	end
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ns

// core-side bench: a byte model of memory, compared after barriers
module tb_top;
	logic ref_clk, reset_n, ce, req_valid, req_ready, perm_fault, lookup_hit;
	logic done_q, fault_q, rd_no_alloc, cache_valid, cache_ack, cache_dirty, bus_valid, bus_ack;
	logic slow, dirty, pf_s, hit_s, dirty_s; // *_s: set before the next request
	logic [3:0] ld_pend, st_pend;
	logic [31:0] dest_index;
	logic [511:0] cache_data;
	wsf_pkg::wsf_req_t req;
	wsf_pkg::wsf_mtype_t rd_mtype, last_mt; // last_mt: type of last bus write
	wsf_pkg::wsf_creq_t cache_req;
	wsf_pkg::wsf_breq_t bus_req;
	logic [7:0] exp_mem [int]; // bytes memory should hold
	logic [7:0] bus_mem [int]; // bytes the bus wrote
	int n_errors = 0;
	int check_count = 0;
	int seed = 13;
	int n_wr = 0;  // line writes on the bus
	int n_inv = 0; // invalidate broadcasts
	wsf_pkg::wsf_mtype_t mts [4] = '{wsf_pkg::MT_UNCACHED, wsf_pkg::MT_COMBINE,
		wsf_pkg::MT_BACK, wsf_pkg::MT_THROUGH};
	wsf_pkg::wsf_op_t sops [3] = '{wsf_pkg::OP_NT_INT, wsf_pkg::OP_NT_PS, wsf_pkg::OP_NT_MASK};

	wsf_unit #(.IN_PLACE(1'b0)) uut (.*);
	wsf_mem_model u_mem (.*);

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// log acknowledged bus writes and broadcasts
	always @(posedge ref_clk) begin
		if (bus_valid === 1'b1 && bus_ack === 1'b1 && bus_req.cmd == wsf_pkg::BC_WRITE) begin
			n_wr++;
			last_mt = bus_req.mtype;
			for (int i = 0; i < 64; i++)
				if (bus_req.be[i])
					bus_mem[int'({bus_req.addr[31:6], 6'h00}) + i] = bus_req.data[8*i +: 8];
		end
		if (bus_valid === 1'b1 && bus_ack === 1'b1 && bus_req.cmd == wsf_pkg::BC_INVAL)
			n_inv++;
		rd_mtype <= mts[$unsigned($random(seed)) % 4];
		slow <= $random(seed);
	end
	always @(negedge ref_clk)
		if (reset_n)
			chk("rd_no_alloc", rd_mtype == wsf_pkg::MT_COMBINE, rd_no_alloc);

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
		check_count++;
		if (e !== s) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask

	// offer, drop at the taking edge, await retirement; pending clears after hold
	task automatic op(input wsf_pkg::wsf_req_t r, input int di, input logic ef, input int hold,
		input logic [3:0] lp, input logic [3:0] sp, output int n);
		@(posedge ref_clk);
		req <= r;
		dest_index <= di;
		req_valid <= 1'b1;
		{ld_pend, st_pend} <= {lp, sp};
		{perm_fault, lookup_hit, dirty} <= {pf_s, hit_s, dirty_s};
		do @(negedge ref_clk); while (req_ready !== 1'b1);
		@(posedge ref_clk);
		req_valid <= 1'b0;
		for (n = 0; n < 500; n++) begin
			@(negedge ref_clk);
			if (done_q === 1'b1)
				break;
			@(posedge ref_clk);
			if (n == hold)
				{ld_pend, st_pend} <= 8'h00;
		end
		chk("done_q", 1'b1, done_q);
		chk("fault_q", ef, fault_q);
	endtask

	// a cached line as the partner reports it
	task automatic fill_line(input int a);
		for (int i = 0; i < 64; i++)
			exp_mem[(a & ~63) + i] = 8'((a & ~63) >> (8 * (i % 4)));
	endtask

	// one streaming store; the model keeps its bytes
	task automatic st(input wsf_pkg::wsf_op_t o, input int a, input wsf_pkg::wsf_mtype_t mt);
		wsf_pkg::wsf_req_t r;
		int n;
		r.op = o;
		r.mtype = mt;
		r.data = {$random(seed), $random(seed), $random(seed), $random(seed)};
		r.mask = {$random(seed), $random(seed), $random(seed), $random(seed)};
		r.addr = (o == wsf_pkg::OP_NT_MASK) ? $random(seed) : a;
		if (hit_s && dirty_s && (mt == wsf_pkg::MT_BACK || mt == wsf_pkg::MT_THROUGH))
			fill_line(a);
		for (int b = 0; b < 16; b++)
			if (a % 64 + b < 64 && (o != wsf_pkg::OP_NT_MASK || r.mask[b][7]))
				exp_mem[a + b] = r.data[8*b +: 8];
		op(r, a, 1'b0, 0, 4'h0, 4'h0, n);
	endtask

	task automatic fence(input wsf_pkg::wsf_op_t o, input int hold, input logic [3:0] lp,
		input logic [3:0] sp, output int n);
		wsf_pkg::wsf_req_t r;
		r = '0;
		r.op = o;
		op(r, 0, 1'b0, hold, lp, sp, n);
	endtask

	task automatic cmp_mem();
		foreach (exp_mem[a])
			chk($sformatf("byte %h", a), exp_mem[a], bus_mem.exists(a) ? bus_mem[a] : 8'hxx);
	endtask

	task automatic final_report();
		if (n_errors == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		wsf_pkg::wsf_req_t r;
		wsf_pkg::wsf_op_t o;
		int n, w, v, a;
		{reset_n, req_valid, perm_fault, lookup_hit, slow, dirty, pf_s, hit_s, dirty_s} = '0;
		{ld_pend, st_pend, dest_index} = '0;
		ce = 1'b1;
		req = '0;
		rd_mtype = wsf_pkg::MT_UNCACHED;
		repeat (5) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		// misaligned packed stores fault
		for (int k = 1; k < 16; k += 7) begin
			r = '0;
			r.op = wsf_pkg::OP_NT_PS;
			r.addr = 32'h2000 + k;
			op(r, 0, 1'b1, 0, 4'h0, 4'h0, n);
		end
		// random stores on two lines, barrier every sixth
		for (int i = 0; i < 24; i++) begin
			o = sops[$unsigned($random(seed)) % 3];
			a = 32'h1000 + ($random(seed) & 32'h7f);
			a = (o == wsf_pkg::OP_NT_PS) ? a & ~15 : a;
			hit_s = $random(seed);
			st(o, a, wsf_pkg::MT_COMBINE);
			if (i % 6 == 5) begin
				fence(wsf_pkg::OP_SFENCE, 4, 4'h0, 4'h3, n);
				chk("sfence wait", 1'b1, n > 4);
				cmp_mem();
			end
		end
		// load and store barriers ignore the other kind's traffic; the full barrier waits on loads
		st(wsf_pkg::OP_NT_INT, 32'h3000, wsf_pkg::MT_COMBINE);
		w = n_wr;
		fence(wsf_pkg::OP_LFENCE, 40, 4'h0, 4'h7, n);
		chk("lfence early", 1'b1, n < 40);
		chk("lfence kept data", w, n_wr);
		fence(wsf_pkg::OP_MFENCE, 5, 4'h2, 4'h0, n);
		chk("mfence wait", 1'b1, n > 5);
		cmp_mem();
		fence(wsf_pkg::OP_SFENCE, 40, 4'h5, 4'h0, n);
		chk("sfence early", 1'b1, n < 40);
		// same-line stores of two types: one write, first type
		hit_s = 1'b0;
		w = n_wr;
		st(wsf_pkg::OP_NT_INT, 32'h4000, wsf_pkg::MT_COMBINE);
		st(wsf_pkg::OP_NT_INT, 32'h4008, wsf_pkg::MT_BACK);
		fence(wsf_pkg::OP_SFENCE, 0, 4'h0, 4'h0, n);
		chk("merged writes", w + 1, n_wr);
		chk("bus type", wsf_pkg::MT_COMBINE, last_mt);
		// dirty cached copies go out ahead of the streaming bytes
		{hit_s, dirty_s} = 2'b11;
		for (int k = 2; k < 4; k++)
			st(wsf_pkg::OP_NT_INT, 32'h5008 + 64 * k, mts[k]);
		fence(wsf_pkg::OP_SFENCE, 0, 4'h0, 4'h0, n);
		cmp_mem();
		// flushes over types, line states and faults
		for (int k = 0; k < 12; k++) begin
			{dirty_s, pf_s} = 2'(k);
			{w, v} = {n_wr, n_inv};
			r = '0;
			r.op = wsf_pkg::OP_FLUSH;
			r.addr = 32'h6005 + 64 * k;
			r.mtype = mts[k / 4];
			op(r, 0, pf_s, 0, 4'h0, 4'h0, n);
			if (!pf_s && dirty_s)
				fill_line(r.addr);
			chk("flush writes", !pf_s && dirty_s, n_wr - w);
			chk("flush bcast", !pf_s, n_inv - v);
		end
		cmp_mem();
		final_report();
	end

	// over twenty times the expected run
	initial begin
		#2000000;
		n_errors++;
		final_report();
	end
endmodule
